/* File: rtl/hfc_ctrl.sv */
// Purpose: Controller that drives a depth-chained or standalone array of asynchronous
//          FIFO devices through their strobe, reset, rewind and mode pins.
// Assumes: Device flags arrive synchronous to clock; the board wires each chain-out to
//          the next chain-in and the last chain-out back to the first chain-in.
// Notes:   One strobe at a time; reads land in a two-entry buffer so a stalled
//          receiver never loses a word.

`timescale 1ns/1ps

module hfc_ctrl (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  // Commands from the local system
  input  wire logic                            depth_mode,
  input  wire logic                            reset_req,
  input  wire logic                            rewind_req,
  // Words to store
  input  wire logic                            wr_valid,
  output logic                                 wr_ready,
  input  wire logic [hfc_pkg::DATA_W-1:0]      wr_data,
  // Words fetched
  output logic                                 rd_valid,
  input  wire logic                            rd_ready,
  output logic      [hfc_pkg::DATA_W-1:0]      rd_data,
  // Status toward the local system
  output logic                                 array_ready,
  output logic                                 depth_active,
  output logic                                 rewind_refused,
  output logic                                 array_empty,
  output logic                                 array_full,
  // Strobes shared by every device of the array
  output logic                                 write_n,
  output logic                                 read_n,
  output logic                                 reset_in_n,
  output logic                                 rewind_read_n,
  output logic      [hfc_pkg::DATA_W-1:0]      data_to_fifo,
  input  wire logic [hfc_pkg::DATA_W-1:0]      data_from_fifo,
  // Mode pins of the chained devices
  output logic      [hfc_pkg::NUM_DEV-1:0]     first_load_select_n,
  output logic                                 chain_in_n_out,
  output logic                                 chain_in_n_oe,
  // One flag pair from each chained device
  input  wire logic [hfc_pkg::NUM_DEV-1:0]     empty_indicator_n,
  input  wire logic [hfc_pkg::NUM_DEV-1:0]     full_indicator_n
);

  hfc_pkg::hfc_state_e               state_reg;
  hfc_pkg::hfc_state_e               state_next;
  logic [hfc_pkg::TIMER_W-1:0]       timer_reg;
  logic [hfc_pkg::TIMER_W-1:0]       timer_next;
  logic [hfc_pkg::DATA_W-1:0]        wdata_reg;
  logic                              mode_reg;
  logic                              init_reg;
  logic                              reset_pend_reg;
  logic                              rewind_pend_reg;
  logic                              refused_reg;
  logic                              read_last_reg;
  logic                              timer_done;
  logic                              comp_empty_n;
  logic                              comp_full_n;
  logic                              idle;
  logic                              can_read;
  logic                              can_write;
  logic                              go_reset;
  logic                              go_rewind;
  logic                              go_read;
  logic                              go_write;
  logic                              rewind_bad;
  logic                              sample_read;
  logic                              buf_in_ready;

  // ==========================================================================
  // Composite flags and request arbitration
  // ==========================================================================
  // An active-low composite flag asserts only when every device asserts it.
  // One flag pair from each device of the depth chain reaches this controller.
  // Each system watches only the flags of the devices that it strobes.
  assign comp_empty_n = |empty_indicator_n;
  assign comp_full_n  = |full_indicator_n;
  assign idle         = (state_reg == hfc_pkg::ST_IDLE) & init_reg;
  assign timer_done   = (timer_reg == '0);

  // A rewind in depth-chained mode is refused, not issued.
  assign rewind_bad = idle & rewind_pend_reg & mode_reg;
  assign go_reset   = (state_reg == hfc_pkg::ST_IDLE) & reset_pend_reg;
  assign go_rewind  = idle & ~reset_pend_reg & rewind_pend_reg & ~mode_reg;

  // Reads need a free buffer entry; writes are never started while full.
  // Flags are trusted only in idle, past every cycle time.
  assign can_read  = idle & ~reset_pend_reg & ~rewind_pend_reg & comp_empty_n & buf_in_ready;
  assign can_write = idle & ~reset_pend_reg & ~rewind_pend_reg & comp_full_n;
  assign go_read   = can_read & (~can_write | ~wr_valid | ~read_last_reg);
  assign go_write  = can_write & wr_valid & ~go_read;
  assign wr_ready  = go_write;

  // The read word is taken on the last low cycle of the read strobe.
  assign sample_read = (state_reg == hfc_pkg::ST_READ_LOW) & timer_done;

  // ==========================================================================
  // State sequencing
  // ==========================================================================
  // Every pulse and its tail are timed by one down-counter.
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_done ? timer_reg : timer_reg - 1'b1;
    case (state_reg)
      hfc_pkg::ST_RESET_LOW:
      begin
        if (timer_done)
        begin
          state_next = hfc_pkg::ST_RESET_TAIL;
          timer_next = hfc_pkg::RESET_TAIL_LOAD;
        end
      end
      hfc_pkg::ST_RESET_TAIL:
      begin
        if (timer_done)
          state_next = hfc_pkg::ST_IDLE;
      end
      hfc_pkg::ST_IDLE:
      begin
        if (go_reset)
        begin
          state_next = hfc_pkg::ST_RESET_LOW;
          timer_next = hfc_pkg::RESET_PULSE_LOAD;
        end
        else if (go_rewind)
        begin
          state_next = hfc_pkg::ST_REWIND_LOW;
          timer_next = hfc_pkg::REWIND_PULSE_LOAD;
        end
        else if (go_read)
        begin
          state_next = hfc_pkg::ST_READ_LOW;
          timer_next = hfc_pkg::STROBE_PULSE_LOAD;
        end
        else if (go_write)
        begin
          state_next = hfc_pkg::ST_WRITE_LOW;
          timer_next = hfc_pkg::STROBE_PULSE_LOAD;
        end
      end
      hfc_pkg::ST_WRITE_LOW:
      begin
        if (timer_done)
        begin
          state_next = hfc_pkg::ST_WRITE_TAIL;
          timer_next = hfc_pkg::STROBE_TAIL_LOAD;
        end
      end
      hfc_pkg::ST_READ_LOW:
      begin
        if (timer_done)
        begin
          state_next = hfc_pkg::ST_READ_TAIL;
          timer_next = hfc_pkg::STROBE_TAIL_LOAD;
        end
      end
      hfc_pkg::ST_REWIND_LOW:
      begin
        if (timer_done)
        begin
          state_next = hfc_pkg::ST_REWIND_TAIL;
          timer_next = hfc_pkg::REWIND_TAIL_LOAD;
        end
      end
      hfc_pkg::ST_WRITE_TAIL,
      hfc_pkg::ST_READ_TAIL,
      hfc_pkg::ST_REWIND_TAIL:
      begin
        if (timer_done)
          state_next = hfc_pkg::ST_IDLE;
      end
      default:
      begin
        state_next = hfc_pkg::ST_IDLE;
        timer_next = '0;
      end
    endcase
  end

  // State and timer registers; controller reset starts a device reset at once.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= hfc_pkg::ST_RESET_LOW;
      timer_reg <= hfc_pkg::RESET_PULSE_LOAD;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // ==========================================================================
  // Pending requests and mode capture
  // ==========================================================================
  // Requests stay pending until served, a rewind also until refused or dropped by a device reset; a new request wins over the clear.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_pend_reg  <= 1'b0;
      rewind_pend_reg <= 1'b0;
      refused_reg     <= 1'b0;
    end
    else
    begin
      reset_pend_reg  <= reset_req | (reset_pend_reg & ~go_reset);
      rewind_pend_reg <= rewind_req | (rewind_pend_reg & ~(go_rewind | rewind_bad | go_reset));
      refused_reg     <= rewind_bad;
    end
  end

  // The mode is caught while the device reset pin is low and holds until the next one.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= 1'b0;
      init_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == hfc_pkg::ST_RESET_LOW)
        mode_reg <= depth_mode;
      if (state_reg == hfc_pkg::ST_RESET_LOW)
        init_reg <= 1'b0;
      else if ((state_reg == hfc_pkg::ST_RESET_TAIL) && timer_done)
        init_reg <= 1'b1;
    end
  end

  // Write data is held from the strobe's fall through its tail; reads and writes alternate.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdata_reg     <= '0;
      read_last_reg <= 1'b0;
    end
    else
    begin
      if (go_write)
        wdata_reg <= wr_data;
      if (go_read)
        read_last_reg <= 1'b1;
      else if (go_write)
        read_last_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Pin drive
  // ==========================================================================
  // Strobes are low only in their own low states, so at most one is low at once.
  // The first device alone sees load-select low in depth mode.
  // In standalone mode the first device's chain-in is pulled low, else the board
  // ring of chain-out to chain-in carries it.
  // In depth mode the pin is released, so the ring sets chain-in timing.
  // The first device accepts strobes at once; later devices follow the chain token,
  // so the strobes run shared and unchanged across the array.
  assign write_n       = (state_reg != hfc_pkg::ST_WRITE_LOW);
  assign read_n        = (state_reg != hfc_pkg::ST_READ_LOW);
  assign reset_in_n    = (state_reg != hfc_pkg::ST_RESET_LOW);
  assign rewind_read_n = (state_reg != hfc_pkg::ST_REWIND_LOW);
  assign data_to_fifo  = wdata_reg;
  assign chain_in_n_out = 1'b0;
  assign chain_in_n_oe  = ~mode_reg;
  for (genvar d = 0; d < hfc_pkg::NUM_DEV; d++)
  begin : g_load_sel
    assign first_load_select_n[d] = mode_reg ? (d != 0) : 1'b1;
  end

  // Status toward the local system.
  assign array_ready    = init_reg;
  assign depth_active   = mode_reg;
  assign rewind_refused = refused_reg;
  assign array_empty    = ~comp_empty_n;
  assign array_full     = ~comp_full_n;

  // ==========================================================================
  // Read buffer
  // ==========================================================================
  // A read is started only when an entry is free, so the sampled word always fits.
  hfc_word_buf #(
    .WIDTH (hfc_pkg::DATA_W),
    .DEPTH (hfc_pkg::BUF_DEPTH)
  ) u_rd_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (sample_read),
    .in_ready  (buf_in_ready),
    .in_data   (data_from_fifo),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

endmodule

/* File: rtl/hfc_pkg.sv */
// Purpose: Shared constants and types for the chained FIFO array controller.
// Assumes: A 200 MHz controller clock.
//          Strobe timing is taken from the slowest speed grade so that every grade is served.
// Notes:   Times are kept in ns and turned into whole cycles, rounding up.

package hfc_pkg;

  // ==========================================================================
  // Array shape
  // ==========================================================================
  localparam int DATA_W    = 9;   // Word width of one device.
  localparam int NUM_DEV   = 3;   // Devices in the depth chain.
  localparam int DEV_WORDS = 512; // Words held by one device.
  localparam int BUF_DEPTH = 2;   // Entries in the read-side buffer.
  localparam int TIMER_W   = 6;   // Width of the strobe timer.

  // ==========================================================================
  // Clock and pin timing
  // ==========================================================================
  localparam int CLK_MHZ         = 200;
  localparam int STROBE_PULSE_NS = 200; // Least low time of a write or read strobe.
  localparam int STROBE_CYCLE_NS = 235; // Least write or read cycle time.
  localparam int STROBE_REC_NS   = 35;  // Least recovery after a write or read strobe.
  localparam int REWIND_PULSE_NS = 200; // Least low time of the rewind-read pin.
  localparam int REWIND_CYCLE_NS = 235; // Rewind cycle time, flags valid after it.
  localparam int REWIND_REC_NS   = 35;  // Least recovery after the rewind-read pin.
  localparam int RESET_PULSE_NS  = 200; // Least low time of the device reset pin.
  localparam int RESET_CYCLE_NS  = 235; // Reset cycle time, flags valid after it.
  localparam int RESET_REC_NS    = 35;  // Least recovery after the reset pin.

  // Whole cycles for each time, rounded up.
  localparam int STROBE_PULSE_C = (STROBE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYCLE_C = (STROBE_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_REC_C   = (STROBE_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int REWIND_PULSE_C = (REWIND_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int REWIND_CYCLE_C = (REWIND_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int REWIND_REC_C   = (REWIND_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_PULSE_C  = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CYCLE_C  = (RESET_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_REC_C    = (RESET_REC_NS * CLK_MHZ + 999) / 1000;

  // High time after each pulse: the larger of recovery and cycle less pulse.
  localparam int STROBE_TAIL_C = (STROBE_CYCLE_C - STROBE_PULSE_C > STROBE_REC_C) ?
                                 STROBE_CYCLE_C - STROBE_PULSE_C : STROBE_REC_C;
  localparam int REWIND_TAIL_C = (REWIND_CYCLE_C - REWIND_PULSE_C > REWIND_REC_C) ?
                                 REWIND_CYCLE_C - REWIND_PULSE_C : REWIND_REC_C;
  localparam int RESET_TAIL_C  = (RESET_CYCLE_C - RESET_PULSE_C > RESET_REC_C) ?
                                 RESET_CYCLE_C - RESET_PULSE_C : RESET_REC_C;

  // Timer loads, one less than the cycle count because the timer ends at zero.
  localparam logic [TIMER_W-1:0] STROBE_PULSE_LOAD = TIMER_W'(STROBE_PULSE_C - 1);
  localparam logic [TIMER_W-1:0] STROBE_TAIL_LOAD  = TIMER_W'(STROBE_TAIL_C - 1);
  localparam logic [TIMER_W-1:0] REWIND_PULSE_LOAD = TIMER_W'(REWIND_PULSE_C - 1);
  localparam logic [TIMER_W-1:0] REWIND_TAIL_LOAD  = TIMER_W'(REWIND_TAIL_C - 1);
  localparam logic [TIMER_W-1:0] RESET_PULSE_LOAD  = TIMER_W'(RESET_PULSE_C - 1);
  localparam logic [TIMER_W-1:0] RESET_TAIL_LOAD   = TIMER_W'(RESET_TAIL_C - 1);

  // ==========================================================================
  // Controller states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_RESET_LOW,
    ST_RESET_TAIL,
    ST_IDLE,
    ST_WRITE_LOW,
    ST_WRITE_TAIL,
    ST_READ_LOW,
    ST_READ_TAIL,
    ST_REWIND_LOW,
    ST_REWIND_TAIL
  } hfc_state_e;

endpackage

/* File: rtl/hfc_word_buf.sv */
// Purpose: Two-entry word buffer with valid and ready on both sides.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Ready on the fill side falls only when both entries hold data.

`timescale 1ns/1ps

module hfc_word_buf #(
  parameter int WIDTH = hfc_pkg::DATA_W,
  parameter int DEPTH = hfc_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_idx_reg;
  logic [PW-1:0]    rd_idx_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;
  logic [PW-1:0]    wr_idx_next;
  logic [PW-1:0]    rd_idx_next;

  // ==========================================================================
  // Handshake decode
  // ==========================================================================
  // Full and empty come straight from the occupancy count.
  assign in_ready    = (count_reg != (PW + 1)'(DEPTH));
  assign out_valid   = (count_reg != '0);
  assign push        = in_valid & in_ready;
  assign pop         = out_valid & out_ready;
  assign out_data    = mem_reg[rd_idx_reg];
  assign wr_idx_next = (wr_idx_reg == PW'(DEPTH - 1)) ? '0 : wr_idx_reg + 1'b1;
  assign rd_idx_next = (rd_idx_reg == PW'(DEPTH - 1)) ? '0 : rd_idx_reg + 1'b1;

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Each entry loads only when the write index points at it.
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
        mem_reg[i] <= '0;
      else if (push && (wr_idx_reg == PW'(i)))
        mem_reg[i] <= in_data;
    end
  end

  // Indices and occupancy move with the two handshakes.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_idx_reg <= '0;
      rd_idx_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_idx_reg <= wr_idx_next;
      if (pop)
        rd_idx_reg <= rd_idx_next;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule

/* File: verification/hfc_ctrl_assertions.sv */
// Purpose: Port checks for the FIFO array controller.
// Assumes: One clock domain with the asynchronous reset rst_n.
// Notes:   Pulse counts match the package timing at 200 MHz.

`timescale 1ns/1ps

module hfc_ctrl_chk (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Watched outputs and flags
  input wire logic       wr_ready,
  input wire logic       depth_active,
  input wire logic       rewind_refused,
  input wire logic       array_empty,
  input wire logic       array_full,
  input wire logic       write_n,
  input wire logic       read_n,
  input wire logic       reset_in_n,
  input wire logic       rewind_read_n,
  input wire logic [2:0] first_load_select_n,
  input wire logic       chain_in_n_oe,
  input wire logic [2:0] empty_indicator_n,
  input wire logic [2:0] full_indicator_n
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic [5:0] lo_t_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Counts the low cycles of the rewind pin.
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) lo_t_reg <= 6'h00;
    else lo_t_reg <= rewind_read_n ? 6'h00 : lo_t_reg + 6'h01;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  chk_rewind_width: assert property ($rose(rewind_read_n) |-> lo_t_reg == 6'h28)
    else $error("rewind pulse not 40 cycles");
  chk_rewind_rec: assert property ($rose(rewind_read_n) |->
    (write_n && read_n && rewind_read_n)[*7]) else $error("strobe inside rewind tail");
  chk_one_strobe: assert property ($onehot0({~write_n, ~read_n, ~rewind_read_n,
    ~reset_in_n})) else $error("two strobes low at once");
  chk_no_chain_rewind: assert property (depth_active |-> rewind_read_n)
    else $error("rewind in chained mode");
  chk_refuse_pulse: assert property (rewind_refused |-> depth_active ##1 !rewind_refused)
    else $error("bad refusal pulse");
  chk_load_select: assert property (first_load_select_n ==
    (depth_active ? 3'h6 : 3'h7)) else $error("load select wrong");
  chk_standalone_pin: assert property (chain_in_n_oe == !depth_active)
    else $error("chain-in drive wrong");
  chk_full_refuse: assert property (array_full |-> !wr_ready)
    else $error("write offered while full");
  chk_flag_join: assert property (array_empty == !(|empty_indicator_n) &&
    array_full == !(|full_indicator_n)) else $error("composite flag wrong");
endmodule

bind hfc_ctrl hfc_ctrl_chk u_chk (.*);

/* File: verification/hfc_fifo_model.sv */
// Purpose: Behavioural model of the chained FIFO array on the far side.
// Assumes: All devices share strobes; in depth mode the later ones hold no words.
// Notes: Depth is cut to DEPTH words, so no chain-out pulse is ever due.

`timescale 1ns/1ps

module hfc_fifo_model #(
  parameter int DEPTH = 4
) (
  // Strobes and data from the controller
  input wire logic       write_n,
  input wire logic       read_n,
  input wire logic       reset_in_n,
  input wire logic       rewind_read_n,
  input wire logic [8:0] data_to_fifo,
  input wire logic [2:0] first_load_select_n,
  // Data and flags back
  output logic     [8:0] data_from_fifo,
  output logic     [2:0] empty_indicator_n,
  output logic     [2:0] full_indicator_n
);
  logic [8:0] mem [8];
  logic [2:0] wp = 3'h0; // Three-bit positions wrap at the end.
  logic [2:0] rp = 3'h0;
  logic [8:0] last = 9'h000;
  logic       wok = 1'b0;
  logic       solo;

  // Flags follow the distance at once, so they are valid after any cycle.
  // In depth mode the later devices wait for chain-in, so they stay empty.
  assign solo              = first_load_select_n[0];
  assign empty_indicator_n = {{2{solo && wp != rp}}, wp != rp};
  assign full_indicator_n  = {{2{!solo || (wp - rp) != 3'(DEPTH)}},
                              (wp - rp) != 3'(DEPTH)};
  // A released bus shows the inverse of the last word read.
  assign data_from_fifo = read_n ? ~last : mem[rp];

  // Reset returns both positions to the start.
  always @(negedge reset_in_n) begin wp = 3'h0; rp = 3'h0; end
  // A write that begins while full is ignored.
  always @(negedge write_n) wok = full_indicator_n[0] && reset_in_n === 1'b1;
  // Data is stored at the end of the write strobe.
  always @(posedge write_n) if (wok) begin mem[wp] = data_to_fifo; wp = wp + 3'h1; end
  // A read moves on at the end of its strobe.
  always @(posedge read_n) if (reset_in_n === 1'b1) begin last = mem[rp]; rp = rp + 3'h1; end
  // Rewind moves only the read position back to the start.
  always @(posedge rewind_read_n) if (reset_in_n === 1'b1) rp = 3'h0;
endmodule

/* File: verification/tb_hfc_ctrl.sv */
// Purpose: Self-checking bench for the FIFO array controller.
// Assumes: Inputs change on the falling clock edge.
// Notes:   The far-side model is cut to four words.

`timescale 1ns/1ps

module tb_hfc_ctrl;
  logic       clock = 1'b0, rst_n = 1'b0, depth_mode = 1'b0, reset_req = 1'b0;
  logic       rewind_req = 1'b0, wr_valid = 1'b0, rd_ready = 1'b1;
  logic [8:0] wr_data = 9'h000, rd_data, data_to_fifo, data_from_fifo;
  logic       wr_ready, rd_valid, array_ready, depth_active, rewind_refused;
  logic       array_empty, array_full, write_n, read_n, reset_in_n, rewind_read_n;
  logic       chain_in_n_out, chain_in_n_oe;
  logic [2:0] first_load_select_n, empty_indicator_n, full_indicator_n;
  int         err_total = 0, num_checks = 0, i, n;

  hfc_ctrl dut (.*);
  hfc_fifo_model #(.DEPTH(4)) u_far (.*);

  // ==========================================================================
  // Clock, checks and closing
  // ==========================================================================
  always #2.5 clock = ~clock;

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Offers one word and holds it until taken.
  task automatic push(input logic [8:0] w);
    wr_valid = 1'b1;
    wr_data = w;
    #1;
    for (i = 0; i < 400 && wr_ready !== 1'b1; i++) #5;
    check(wr_ready, 1'b1);
    @(negedge clock);
    wr_valid = 1'b0;
    @(negedge clock);
  endtask

  // Waits for a fetched word and compares it.
  task automatic pull(input logic [8:0] w);
    #1;
    for (i = 0; i < 400 && rd_valid !== 1'b1; i++) #5;
    check(rd_data, w);
    @(negedge clock);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Device reset follows controller reset; standalone pins after.
  task automatic t_reset;
    check(reset_in_n, 1'b0);
    rst_n = 1'b1;
    for (i = 0; i < 100 && array_ready !== 1'b1; i++) @(negedge clock);
    check(i > 40 && i < 60, 1'b1);
    check(first_load_select_n, 3'h7);
    check(chain_in_n_oe, 1'b1);
    check(chain_in_n_out, 1'b0);
  endtask

  // Receiver stalls: buffer and far side fill, then drain in order.
  task automatic t_fill;
    rd_ready = 1'b0;
    for (int k = 0; k < 6; k++) push(9'h1A0 + 9'(k));
    wr_valid = 1'b1;
    wr_data = 9'h0FF;
    n = 0;
    for (i = 0; i < 150; i++)
    begin
      @(negedge clock);
      n += (wr_ready === 1'b1) || (read_n !== 1'b1);
    end
    wr_valid = 1'b0;
    check(n[8:0], 9'h000);
    check(array_full, 1'b1);
    rd_ready = 1'b1;
    for (int k = 0; k < 6; k++) pull(9'h1A0 + 9'(k));
  endtask

  // Rewind brings back the oldest words.
  task automatic t_rewind;
    rewind_req = 1'b1;
    @(negedge clock);
    rewind_req = 1'b0;
    pull(9'h1A0);
    pull(9'h1A1);
    repeat (400) @(negedge clock);
  endtask

  // Chained mode: load select, refused rewind, first device works.
  task automatic t_depth;
    depth_mode = 1'b1;
    reset_req = 1'b1;
    @(negedge clock);
    reset_req = 1'b0;
    for (i = 0; i < 400 && array_ready !== 1'b0; i++) @(negedge clock);
    for (i = 0; i < 100 && array_ready !== 1'b1; i++) @(negedge clock);
    check(first_load_select_n, 3'h6);
    check(chain_in_n_oe, 1'b0);
    check(array_empty, 1'b1);
    rewind_req = 1'b1;
    @(negedge clock);
    rewind_req = 1'b0;
    for (i = 0; i < 100 && rewind_refused !== 1'b1; i++) @(negedge clock);
    check(rewind_refused, 1'b1);
    push(9'h055);
    pull(9'h055);
  endtask

  // Main sequence.
  initial
  begin
    repeat (3) @(negedge clock);
    t_reset;
    t_fill;
    t_rewind;
    t_depth;
    end_of_test;
  end

  // Watchdog well beyond the expected run of under two thousand cycles.
  initial
  begin
    #100000;
    err_total++;
    end_of_test;
  end
endmodule
